// ==== float_reg_arith_unit.sv ====
// Register to register floating point add, subtract, multiply, divide
`timescale 1ns/10ps
module float_reg_arith_unit
    import float_arith_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic [15:0] regRdData,
    output logic [3:0] regAddr,
    output logic [15:0] regWrData,
    output logic regWrEn,
    output logic busy,
    output logic done,
    output logic trapReq,
    output logic unsupportedOp
);
    fpu_state_t state_q;
    logic [3:0] opcode_q;
    logic [3:0] destField_q;
    logic [3:0] srcField_q;
    logic dbl_q;
    logic [2:0] rdIdx_q;
    logic [1:0] wrIdx_q;
    logic [2:0][15:0] opA_q;
    logic [2:0][15:0] opB_q;
    logic resSign_q;
    logic [8:0] resExp_q;
    logic [37:0] resFrac_q;
    logic ovf_q;
    logic [TIMER_WIDTH-1:0] cycleCnt_q;
    logic [3:0] regAddr_q;
    logic [15:0] regWrData_q;
    logic regWrEn_q;
    logic done_q;
    logic trap_q;
    logic unsup_q;

    // Second word pairs with the odd register; triples run upward
    function automatic logic [3:0] wordAddr(input logic [3:0] base,
        input logic [1:0] idx, input logic dbl);
        wordAddr = dbl ? base + {2'h0, idx} :
            (idx == 2'h0 ? base : base | 4'h1);
    endfunction

    // Packs sign, exponent and a 38-bit fraction, MSB first
    function automatic logic [47:0] unpack(input logic [2:0][15:0] w,
        input logic dbl);
        logic [37:0] f;
        f = {w[0][FRAC_HEAD_WIDTH-1:0], w[1], dbl ? w[2] : 16'h0000};
        unpack = {w[0][SIGN_BIT], w[0][EXP_LSB +: EXP_WIDTH], f};
    endfunction

    function automatic logic [5:0] leadZeros(input logic [37:0] v);
        logic [5:0] n;
        logic hit;
        n = 6'h00;
        hit = 1'b0;
        for (int i = 37; i >= 0; i--)
        begin
            if (v[i])
                hit = 1'b1;
            else if (!hit)
                n = n + 6'h01;
        end
        leadZeros = n;
    endfunction

    // Decode of the incoming instruction
    wire logic [3:0] newClass = instr[CLASS_LSB +: 4];
    wire logic [3:0] newOp = instr[OPCODE_LSB +: 4];
    wire logic [3:0] newDest = instr[DEST_LSB +: 4];
    wire logic [3:0] newSrc = instr[SRC_LSB +: 4];
    wire logic newLegal = (newClass == OP_CLASS_FLOAT) &&
        (newOp <= OP_DOUBLE_MUL);
    wire logic newDbl = newOp[2];
    wire logic accept = (state_q == ST_IDLE) && start;

    wire logic isSub = (opcode_q == OP_SINGLE_SUB) ||
        (opcode_q == OP_DOUBLE_SUB);
    wire logic isMul = (opcode_q == OP_SINGLE_MUL) ||
        (opcode_q == OP_DOUBLE_MUL);
    wire logic isDiv = opcode_q == OP_SINGLE_DIV;
    wire logic [2:0] nWords = dbl_q ? DOUBLE_WORDS : SINGLE_WORDS;
    wire logic [TIMER_WIDTH-1:0] minCycles =
        isDiv ? TIMER_WIDTH'(SDIV_CYCLES) :
        (opcode_q == OP_DOUBLE_MUL) ? TIMER_WIDTH'(DMUL_CYCLES) :
        '0;

    // Operand fetch addressing: destination words first, then source
    wire logic [2:0] rdNext = rdIdx_q + 3'h1;
    wire logic rdLast = rdIdx_q == (nWords + nWords - 3'h1);
    wire logic [2:0] rdNextB = rdNext - nWords;
    wire logic [3:0] rdAddrNext = (rdNext < nWords) ?
        wordAddr(destField_q, rdNext[1:0], dbl_q) :
        wordAddr(srcField_q, rdNextB[1:0], dbl_q);
    wire logic [2:0] rdIdxB = rdIdx_q - nWords;

    // Unpacked operands
    wire logic [47:0] unpA = unpack(opA_q, dbl_q);
    wire logic [47:0] unpB = unpack(opB_q, dbl_q);
    wire logic sA = unpA[47];
    wire logic [8:0] eA = unpA[46:38];
    wire logic [37:0] fA = unpA[37:0];
    wire logic sB = unpB[47] ^ isSub;
    wire logic [8:0] eB = unpB[46:38];
    wire logic [37:0] fB = unpB[37:0];
    wire logic divByZero = isDiv && (fB == 38'h0);

    // Add path: align the smaller exponent, then signed magnitude sum
    wire logic aBig = eA >= eB;
    wire logic [8:0] expX = aBig ? eA : eB;
    wire logic [8:0] expDiff = aBig ? eA - eB : eB - eA;
    wire logic [38:0] magX = {1'b0, aBig ? fA : fB};
    wire logic [38:0] magY = {1'b0, aBig ? fB : fA} >> expDiff;
    wire logic sX = aBig ? sA : sB;
    wire logic sY = aBig ? sB : sA;
    wire logic xGe = magX >= magY;
    wire logic [38:0] addMag = (sX == sY) ? magX + magY :
        (xGe ? magX - magY : magY - magX);
    wire logic addSign = ((sX == sY) || xGe) ? sX : sY;

    // Multiply and divide paths
    wire logic [75:0] mulProd = fA * fB;
    wire logic [38:0] divQ;
    wire logic divDone;
    wire logic divStart = (state_q == ST_CALC) && isDiv && !divByZero;
    wire logic signed [11:0] expAs = $signed({3'h0, eA});
    wire logic signed [11:0] expBs = $signed({3'h0, eB});

    wire logic [38:0] selMag = isDiv ? divQ :
        isMul ? {1'b0, mulProd[75:38]} : addMag;
    wire logic selSign = (isMul || isDiv) ? sA ^ unpB[47] : addSign;
    wire logic signed [11:0] selExp = isDiv ? expAs - expBs + EXP_BIAS :
        isMul ? expAs + expBs - EXP_BIAS : $signed({3'h0, expX});

    // Normalizer shared by every operation
    wire logic [5:0] lz = leadZeros(selMag[37:0]);
    wire logic magZero = selMag == 39'h0;
    wire logic [37:0] normFrac = selMag[38] ? selMag[38:1] :
        selMag[37:0] << lz;
    wire logic signed [11:0] normExp = selMag[38] ? selExp + 12'sh001 :
        selExp - $signed({6'h00, lz});
    wire logic normOvf = !magZero &&
        ((normExp < 12'sh000) || (normExp > EXP_MAX));
    wire logic [37:0] fracMask = dbl_q ? {38{1'b1}} :
        {{SINGLE_FRAC_WIDTH{1'b1}}, 16'h0000};
    wire logic latchRes = ((state_q == ST_CALC) && !isDiv) ||
        ((state_q == ST_DIVWAIT) && divDone);
    wire logic goWrite = !normOvf;

    wire logic [15:0] resWord0 = {resSign_q, resExp_q,
        resFrac_q[37:32]};
    wire logic [15:0] resWordOut = (wrIdx_q == 2'h0) ? resWord0 :
        (wrIdx_q == 2'h1) ? resFrac_q[31:16] : resFrac_q[15:0];

    frac_divider uDivider
    (
        .clk(clk),
        .reset(reset),
        .start(divStart),
        .dividend(fA),
        .divisor(fB),
        .quotient(divQ),
        .done(divDone)
    );

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            opcode_q <= '0;
            destField_q <= '0;
            srcField_q <= '0;
            dbl_q <= 1'b0;
            rdIdx_q <= '0;
            wrIdx_q <= '0;
            opA_q <= '0;
            opB_q <= '0;
            ovf_q <= 1'b0;
            done_q <= 1'b0;
            trap_q <= 1'b0;
            unsup_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            trap_q <= 1'b0;
            unsup_q <= 1'b0;
            unique case (state_q)
                ST_IDLE:
                    if (start && newLegal)
                    begin
                        opcode_q <= newOp;
                        destField_q <= newDest;
                        srcField_q <= newSrc;
                        dbl_q <= newDbl;
                        rdIdx_q <= '0;
                        wrIdx_q <= '0;
                        ovf_q <= 1'b0;
                        state_q <= ST_READ;
                    end
                    else if (start)
                    begin
                        done_q <= 1'b1;
                        unsup_q <= 1'b1;
                    end
                ST_READ:
                begin
                    if (rdIdx_q < nWords)
                        opA_q[rdIdx_q[1:0]] <= regRdData;
                    else
                        opB_q[rdIdxB[1:0]] <= regRdData;
                    rdIdx_q <= rdNext;
                    if (rdLast)
                        state_q <= ST_CALC;
                end
                ST_CALC:
                    if (divByZero)
                    begin
                        ovf_q <= 1'b1;
                        state_q <= ST_HOLD;
                    end
                    else if (isDiv)
                        state_q <= ST_DIVWAIT;
                    else
                    begin
                        ovf_q <= normOvf;
                        state_q <= goWrite ? ST_WRITE : ST_HOLD;
                    end
                ST_DIVWAIT:
                    if (divDone)
                    begin
                        ovf_q <= normOvf;
                        state_q <= goWrite ? ST_WRITE : ST_HOLD;
                    end
                ST_WRITE:
                begin
                    wrIdx_q <= wrIdx_q + 2'h1;
                    if ({1'b0, wrIdx_q} == nWords - 3'h1)
                        state_q <= ST_HOLD;
                end
                ST_HOLD:
                    if (cycleCnt_q >= minCycles)
                    begin
                        done_q <= 1'b1;
                        trap_q <= ovf_q;
                        state_q <= ST_IDLE;
                    end
            endcase
        end
    end

    // Result capture; single results drop the low fraction word
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            resSign_q <= 1'b0;
            resExp_q <= '0;
            resFrac_q <= '0;
        end
        else if (latchRes)
        begin
            resSign_q <= magZero ? 1'b0 : selSign;
            resExp_q <= magZero ? 9'h000 : normExp[8:0];
            resFrac_q <= normFrac & fracMask;
        end
    end

    // Elapsed time since the instruction was taken, saturating
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cycleCnt_q <= '0;
        else if (accept)
            cycleCnt_q <= '0;
        else if (cycleCnt_q != {TIMER_WIDTH{1'b1}})
            cycleCnt_q <= cycleCnt_q + TIMER_WIDTH'(1);
    end

    // Register file port; reads see regAddr in the same cycle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            regAddr_q <= '0;
            regWrData_q <= '0;
            regWrEn_q <= 1'b0;
        end
        else
        begin
            regWrEn_q <= state_q == ST_WRITE;
            if (accept)
                regAddr_q <= newDest;
            else if (state_q == ST_READ)
                regAddr_q <= rdAddrNext;
            else if (state_q == ST_WRITE)
            begin
                regAddr_q <= wordAddr(destField_q, wrIdx_q, dbl_q);
                regWrData_q <= resWordOut;
            end
        end
    end

    assign regAddr = regAddr_q;
    assign regWrData = regWrData_q;
    assign regWrEn = regWrEn_q;
    assign busy = state_q != ST_IDLE;
    assign done = done_q;
    assign trapReq = trap_q;
    assign unsupportedOp = unsup_q;

    AST_TRAP_WITH_DONE:
    assert property (@(posedge clk) disable iff (reset)
        trapReq |-> done)
    else $error("trap request without completion");

    AST_TRAP_ONE_CYCLE:
    assert property (@(posedge clk) disable iff (reset)
        trapReq |=> !trapReq && !busy)
    else $error("trap request longer than one cycle");

    AST_SDIV_TIME:
    assert property (@(posedge clk) disable iff (reset)
        (done && isDiv && !unsupportedOp) |->
        cycleCnt_q > TIMER_WIDTH'(SDIV_CYCLES - 1))
    else $error("single divide finished early");

    AST_DMUL_TIME:
    assert property (@(posedge clk) disable iff (reset)
        (done && opcode_q == OP_DOUBLE_MUL && !unsupportedOp) |->
        cycleCnt_q > TIMER_WIDTH'(DMUL_CYCLES - 1))
    else $error("double multiply finished early");

    AST_DIV_ZERO_TRAP:
    assert property (@(posedge clk) disable iff (reset)
        (state_q == ST_CALC && divByZero) |=> ovf_q && !regWrEn)
    else $error("divide by zero not flagged");

    AST_EXP_RANGE:
    assert property (@(posedge clk) disable iff (reset)
        (latchRes && normExp > EXP_MAX && !magZero) |=>
        ovf_q && state_q == ST_HOLD)
    else $error("exponent overflow not flagged");

    AST_NO_WRITE_ON_OVF:
    assert property (@(posedge clk) disable iff (reset)
        regWrEn |-> !ovf_q)
    else $error("result written despite overflow");

    AST_PAIR_ADDR:
    assert property (@(posedge clk) disable iff (reset)
        (regWrEn && !dbl_q) |-> regAddr[3:1] == destField_q[3:1])
    else $error("single result outside the register pair");

    AST_NORMALIZED:
    assert property (@(posedge clk) disable iff (reset)
        (state_q == ST_WRITE && resFrac_q != 38'h0) |-> resFrac_q[37])
    else $error("result fraction not normalized");

    AST_WRITE_COUNT:
    assert property (@(posedge clk) disable iff (reset)
        ($rose(regWrEn) && !dbl_q) |=> regWrEn ##1 !regWrEn)
    else $error("single result not exactly two words");
endmodule

// ==== float_arith_pkg.sv ====
// Constants and types shared by the register floating point unit
// Function
// - Leading word MSB is the fraction sign; one is negative, zero positive.
// - Nine bits after the sign hold the biased exponent, both precisions.
// - Fraction is 22 bits in single, 38 bits in double precision.
// - Single operands and results use two words, double use three.
// - Single pair is even register then next odd; software names even ones.
// - Results are always normalized; only a zero fraction stays unnormalized.
// - Most significant word sits at the lowest register number.
// - Flag overflow or underflow when the result exponent leaves nine bits.
// - Overflow or underflow raises a trap request at interrupt level 5.
// - Single add sums source pair into destination pair.
// - Single subtract takes source from destination, with range overflow.
// - Digits 3 and 2 decode single multiply, product into destination.
// - Digits 3 and 3 decode single divide, 15.4 us, quotient to dest.
// - Single divide also flags overflow when the divisor is zero.
// - Double operands are triples at register 4, 8 or C only; the unit accepts a triple at any base register.
// - Double add sums source triple into destination, range overflow.
// - Double subtract takes source triple from destination triple.
// - Digits 3 and 6 decode double multiply, 20.8 us, product to dest.
// - Group holds 16 ops; register forms here, others refused.
package float_arith_pkg;
    localparam logic [3:0] OP_CLASS_FLOAT = 4'h3;
    localparam logic [3:0] OP_SINGLE_ADD = 4'h0;
    localparam logic [3:0] OP_SINGLE_SUB = 4'h1;
    localparam logic [3:0] OP_SINGLE_MUL = 4'h2;
    localparam logic [3:0] OP_SINGLE_DIV = 4'h3;
    localparam logic [3:0] OP_DOUBLE_ADD = 4'h4;
    localparam logic [3:0] OP_DOUBLE_SUB = 4'h5;
    localparam logic [3:0] OP_DOUBLE_MUL = 4'h6;
    localparam int CLASS_LSB = 12;
    localparam int OPCODE_LSB = 8;
    localparam int DEST_LSB = 4;
    localparam int SRC_LSB = 0;
    localparam int SIGN_BIT = 15;
    localparam int EXP_LSB = 6;
    localparam int EXP_WIDTH = 9;
    localparam int FRAC_HEAD_WIDTH = 6;
    localparam int SINGLE_FRAC_WIDTH = 22;
    localparam int DOUBLE_FRAC_WIDTH = 38;
    localparam logic [2:0] SINGLE_WORDS = 3'h2;
    localparam logic [2:0] DOUBLE_WORDS = 3'h3;
    localparam logic [3:0] TRIPLE_BASE_A = 4'h4;
    localparam logic [3:0] TRIPLE_BASE_B = 4'h8;
    localparam logic [3:0] TRIPLE_BASE_C = 4'hC;
    localparam logic signed [11:0] EXP_BIAS = 12'sh100;
    localparam logic signed [11:0] EXP_MAX = 12'sh1FF;
    localparam int TRAP_LEVEL = 5;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SDIV_TIME_NS = 15400;
    localparam int DMUL_TIME_NS = 20800;
    localparam int SDIV_CYCLES =
        (SDIV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DMUL_CYCLES =
        (DMUL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_WIDTH = 10;
    localparam int DIV_STEPS = 39;
    typedef enum {ST_IDLE, ST_READ, ST_CALC, ST_DIVWAIT, ST_WRITE, ST_HOLD}
        fpu_state_t;
endpackage

// ==== frac_divider.sv ====
// Restoring fraction divider, one quotient bit per clock
`timescale 1ns/10ps
module frac_divider
    import float_arith_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [37:0] dividend,
    input wire logic [37:0] divisor,
    output logic [38:0] quotient,
    output logic done
);
    logic [38:0] rem_q;
    logic [38:0] quot_q;
    logic [5:0] step_q;
    logic run_q;
    logic done_q;
    wire logic geDiv;
    wire logic [38:0] remSub;

    // Divisor must stay stable while running; the caller holds it in flops
    assign geDiv = rem_q >= {1'b0, divisor};
    assign remSub = geDiv ? rem_q - {1'b0, divisor} : rem_q;
    assign quotient = quot_q;
    assign done = done_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rem_q <= '0;
            quot_q <= '0;
            step_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (start)
            begin
                rem_q <= {1'b0, dividend};
                quot_q <= '0;
                step_q <= '0;
                run_q <= 1'b1;
            end
            else if (run_q)
            begin
                quot_q <= {quot_q[37:0], geDiv};
                rem_q <= {remSub[37:0], 1'b0};
                step_q <= step_q + 6'h01;
                if (step_q == 6'(DIV_STEPS - 1))
                begin
                    run_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== reg_file_model.sv ====
// General register file model facing the floating point unit
`timescale 1ns/10ps
module reg_file_model
(
    input wire logic clk,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrEn,
    output logic [15:0] regRdData
);
    logic [15:0] mem [16];
    // Read is combinational; the unit samples data in its address cycle
    assign regRdData = mem[regAddr];
    initial
    begin
        // Distinct filler so a skipped word never reads back as expected
        for (int i = 0; i < 16; i++)
        begin
            mem[i] = 16'h5A5A ^ 16'(i);
        end
    end
    // One word per strobe, at the addressed register
    always @(posedge clk)
    begin
        if (regWrEn)
        begin
            mem[regAddr] <= regWrData;
        end
    end
    task automatic load(input logic [3:0] idx, input logic [15:0] val);
        mem[idx] = val;
    endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the register floating point unit
`timescale 1ns/10ps
`define CHK(g, e) \
    begin \
        comparisons++; \
        if ((g) !== (e)) \
        begin \
            nMismatch++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module tb
    import float_arith_pkg::*;
    ;
    typedef struct {
        logic [3:0] base;
        int nWords;
        logic [47:0] words;
        logic trap;
        logic unsup;
        int lo;
        int hi;
    } note_t;
    logic clk;
    logic reset;
    logic start;
    logic [15:0] instr;
    logic [15:0] regRdData;
    logic [3:0] regAddr;
    logic [15:0] regWrData;
    logic regWrEn;
    logic busy;
    logic done;
    logic trapReq;
    logic unsupportedOp;
    int nMismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0 = 0;
    note_t notes[$];
    note_t seen;
    logic [3:0] bases [3] = '{4'h4, 4'h8, 4'hC};
    logic sg;
    logic [3:0] d;
    int span;
    logic [3:0] wAddr;
    logic [15:0] expWord;

    float_reg_arith_unit DUT (.clk(clk), .reset(reset), .start(start),
        .instr(instr), .regRdData(regRdData), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .busy(busy),
        .done(done), .trapReq(trapReq), .unsupportedOp(unsupportedOp));
    reg_file_model RF (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdData(regRdData));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
    end

    // Leading word of a value with fraction 0.1b
    function automatic logic [15:0] w(input logic s, input logic [8:0] e);
        return {s, e, 6'h20};
    endfunction

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Preload operands, issue one instruction, wait for its completion
    task automatic op(input logic [7:0] opc, input logic [3:0] dst, src,
            input logic [47:0] dW, sW, expW, input int n, lo, hi,
            input logic trap, unsup, poke);
        note_t nt;
        int k;
        for (int i = 0; i < n; i++)
        begin
            RF.load(dst + 4'(i), dW[47-16*i -: 16]);
            RF.load(src + 4'(i), sW[47-16*i -: 16]);
        end
        nt = '{dst, n, expW, trap, unsup, lo, hi};
        @(negedge clk);
        start = 1'b1;
        instr = {opc, dst, src};
        t0 = cyc + 1;
        notes.push_back(nt);
        @(negedge clk);
        // A poke keeps start high into the busy cycle, where it is refused
        start = poke;
        instr = poke ? 16'h3700 : 16'($urandom);
        `CHK(busy, !unsup)
        if (poke)
        begin
            @(negedge clk);
            start = 1'b0;
        end
        k = 0;
        while (done !== 1'b1 && k < 1000)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= 1000)
        begin
            nMismatch++;
            test_done();
        end
        // Let the checker read the results before the next preload
        @(negedge clk);
    endtask

    // Each completion retires the oldest expectation
    always @(negedge clk)
    begin
        if (done === 1'b1)
        begin
            `CHK(notes.size() > 0, 1'b1)
            if (notes.size() > 0)
            begin
                seen = notes.pop_front();
                `CHK(trapReq, seen.trap)
                `CHK(unsupportedOp, seen.unsup)
                span = cyc - t0;
                `CHK(span >= seen.lo && span <= seen.hi, 1'b1)
                for (int i = 0; i < seen.nWords; i++)
                begin
                    wAddr = seen.base + 4'(i);
                    expWord = seen.words[47-16*i -: 16];
                    `CHK(RF.mem[wAddr], expWord)
                end
            end
        end
        else if (trapReq === 1'b1)
        begin
            `CHK(trapReq, 1'b0)
        end
    end

    initial
    begin
        #(40 * 8000);
        nMismatch++;
        test_done();
    end

    initial
    begin
        reset = 1'b1;
        start = 1'b0;
        instr = 16'h0000;
        void'($urandom(52261));
        repeat (2) @(negedge clk);
        reset = 1'b0;
        `CHK({busy, done, regWrEn, trapReq}, 4'h0)
        // Single add, random even pairs and sign; carry right-shifts the second word too
        repeat (3)
        begin
            sg = 1'($urandom);
            d = {3'($urandom), 1'b0};
            op(8'h30, d, d ^ 4'h8, {w(sg, 9'h100), 32'h0},
                {w(sg, 9'h100), 16'h8000, 16'h0},
                {w(sg, 9'h101), 16'h4000, 16'h0}, 2, 0, 60, 0, 0, 0);
        end
        // Subtract order, with a refused request while busy
        op(8'h31, 4'h6, 4'h0, {w(0, 9'h100), 32'h0}, {w(0, 9'h0FF), 32'h0},
            {w(0, 9'h0FF), 32'h0}, 2, 0, 60, 0, 0, 1);
        // Zero plus an unnormalized value comes back normalized
        op(8'h30, 4'hA, 4'hE, 48'h0, {16'h4010, 32'h0},
            {w(0, 9'h0FF), 32'h0}, 2, 0, 60, 0, 0, 0);
        op(8'h32, 4'h8, 4'hC, {w(0, 9'h100), 32'h0}, {w(0, 9'h100), 32'h0},
            {w(0, 9'h0FF), 32'h0}, 2, 0, 60, 0, 0, 0);
        op(8'h33, 4'h0, 4'h2, {w(0, 9'h100), 32'h0}, {w(0, 9'h100), 32'h0},
            {w(0, 9'h101), 32'h0}, 2, 385, 386, 0, 0, 0);
        // Zero divisor traps and leaves the destination alone
        op(8'h33, 4'h0, 4'h2, {w(1, 9'h120), 32'h1234}, 48'h0,
            {w(1, 9'h120), 32'h1234}, 2, 0, 500, 1, 0, 0);
        // Exponent out of range at both ends
        for (int e = 0; e < 2; e++)
            op(8'h32, 4'h4, 4'h6, {w(0, e ? 9'h1FF : 9'h0), 32'h0},
                {w(0, e ? 9'h1FF : 9'h0), 32'h0},
                {w(0, {9{1'(e)}}), 32'h0}, 2, 0, 60, 1, 0, 0);
        // Double add on every legal base, random sign
        for (int i = 0; i < 3; i++)
        begin
            sg = 1'($urandom);
            op(8'h34, bases[i], bases[(i+1)%3], {w(sg, 9'h100), 32'h0},
                {w(sg, 9'h100), 32'h0}, {w(sg, 9'h101), 32'h0},
                3, 0, 60, 0, 0, 0);
        end
        // Bit 1 of the third word survives the shift, landing on bit 2
        op(8'h35, 4'h8, 4'h4, {w(0, 9'h101), 32'h2}, {w(0, 9'h100), 32'h0},
            {w(0, 9'h100), 32'h4}, 3, 0, 60, 0, 0, 0);
        op(8'h36, 4'h4, 4'h8, {w(0, 9'h100), 32'h0}, {w(0, 9'h100), 32'h0},
            {w(0, 9'h0FF), 32'h0}, 3, 520, 521, 0, 0, 0);
        // Double divide, a memory form and a non-float class are refused
        for (int i = 0; i < 3; i++)
            op(i == 0 ? 8'h37 : (i == 1 ? 8'h38 : 8'h20), 4'h2, 4'h6,
                {16'h1111, 32'h2222}, {16'h3333, 32'h4444},
                {16'h1111, 32'h2222}, 2, 0, 60, 0, 1, 0);
        repeat (4) @(negedge clk);
        `CHK(notes.size(), 0)
        test_done();
    end
endmodule
